// file: rtl/mds_cap_calc.sv
// Braking current cap, optionally scaled with motor speed
`timescale 1ns/100ps
module mds_cap_calc import mds_pkg::*; (
  input wire logic [7:0] speed,
  input wire logic [7:0] ceiling,
  input wire logic [7:0] cap_hi,
  input wire logic [7:0] cap_lo,
  input wire logic scale_en,
  output logic [7:0] cap
);
  logic [7:0] spd;
  logic [7:0] span;
  logic [15:0] prod;

  // Linear blend from the zero-speed cap up to the full cap at the ceiling
  always_comb begin
    spd = (speed > ceiling) ? ceiling : speed;
    span = mds_gap(cap_hi, cap_lo);
    prod = span * spd;
    if (!scale_en || ceiling == 8'h00) begin
      cap = cap_hi;
    end else begin
      // Divider is costly and combinational; its result is registered into the cap only while fast slowdown is entered or held
      cap = cap_lo + 8'(prod / {8'h00, ceiling});
    end
  end
endmodule : mds_cap_calc

// file: rtl/mds_cfg.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MDS_CFG_SVH
`define MDS_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MDS_OFF_CTRL 8'h00
`define MDS_OFF_SLOW 8'h04
`define MDS_OFF_WIN 8'h08
`define MDS_OFF_BTIME 8'h0C
`define MDS_OFF_STAT 8'h10

// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define MDS_CTRL_QSE 0
`define MDS_CTRL_SGE 1
`define MDS_CTRL_SCE 2
`define MDS_CTRL_SRE 3
`define MDS_CTRL_STOP_LSB 4
`define MDS_CTRL_STOP_MSB 6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MDS_RST_CTRL 7'h03
`define MDS_RST_SLOW 32'hB3032080
`define MDS_RST_WIN 24'h1A1A26
`define MDS_RST_BTIME 16'h03E8

// ----------------------------------------------------------------
// Timing: one timer tick per microsecond at a 25 ns clock
// ----------------------------------------------------------------
`define MDS_CLK_NS 25
`define MDS_TICK_NS 1000
`define MDS_TICK_CYC ((`MDS_TICK_NS + `MDS_CLK_NS - 1) / `MDS_CLK_NS)

`endif

// file: rtl/mds_ctrl.sv
// Fast slowdown, synchronous rectification and stop sequencing top
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`include "mds_cfg.svh"
module mds_ctrl import mds_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_cmd,
  input wire logic brake_pin,
  input wire logic [7:0] motor_speed,
  input wire logic [7:0] target_speed,
  input wire logic hs_mod_active,
  input wire mds_gate_type comm_drive,
  input wire logic [2:0] upper_reverse_current_cmp,
  input wire logic [2:0] lower_reverse_current_cmp,
  output mds_gate_type gate_drive,
  output logic [7:0] speed_cmd,
  output logic [7:0] current_cap,
  output logic slowdown_active
);

  // ----------------------------------------------------------------
  // State and configuration fields
  // ----------------------------------------------------------------
  localparam mds_state_type MDS_RST_STATE = '{
    st: MDS_ST_RUN, ctrl: `MDS_RST_CTRL, slow: `MDS_RST_SLOW,
    win: `MDS_RST_WIN, btime: `MDS_RST_BTIME, default: '0};
  localparam logic [5:0] TICK_LAST = 6'(`MDS_TICK_CYC - 1);

  mds_state_type s_ff;
  mds_state_type nxt_s;
  logic [7:0] cap_w;
  logic quick_slowdown_enable;
  logic surge_guard_enable;
  logic speed_scaled_cap_enable;
  logic synchronous_rectify_enable;
  logic [2:0] stop_style_select;
  logic [7:0] slowdown_current_cap;
  logic [7:0] zero_speed_current_cap;
  logic [7:0] slowdown_exit_band;
  logic [7:0] slowdown_speed_ceiling;
  logic [7:0] slowdown_min_window;
  logic [7:0] brake_entry_speed;
  logic [7:0] pin_brake_speed;
  logic [15:0] brake_hold_time;
  logic tick;
  logic setup;
  logic access;
  logic fast_ok;
  logic band_hit;
  mds_gate_type driven;

  // Field views of the configuration registers
  assign quick_slowdown_enable = s_ff.ctrl[`MDS_CTRL_QSE];
  // Surge guard enable bit; decoded here but drives nothing and leaves on no port
  assign surge_guard_enable = s_ff.ctrl[`MDS_CTRL_SGE];
  assign speed_scaled_cap_enable = s_ff.ctrl[`MDS_CTRL_SCE];
  assign synchronous_rectify_enable = s_ff.ctrl[`MDS_CTRL_SRE];
  assign stop_style_select =
    s_ff.ctrl[`MDS_CTRL_STOP_MSB:`MDS_CTRL_STOP_LSB];
  assign slowdown_current_cap = s_ff.slow[7:0];
  assign zero_speed_current_cap = s_ff.slow[15:8];
  assign slowdown_exit_band = s_ff.slow[23:16];
  assign slowdown_speed_ceiling = s_ff.slow[31:24];
  assign slowdown_min_window = s_ff.win[7:0];
  assign brake_entry_speed = s_ff.win[15:8];
  assign pin_brake_speed = s_ff.win[23:16];
  assign brake_hold_time = s_ff.btime;

  // Outputs come straight from the state register
  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign gate_drive = s_ff.gate;
  assign speed_cmd = s_ff.speed_cmd;
  assign current_cap = s_ff.cap;
  assign slowdown_active = s_ff.slow_act;

  // ----------------------------------------------------------------
  // Braking current cap
  // ----------------------------------------------------------------
  mds_cap_calc u_cap (
    .speed(motor_speed),
    .ceiling(slowdown_speed_ceiling),
    .cap_hi(slowdown_current_cap),
    .cap_lo(zero_speed_current_cap),
    .scale_en(speed_scaled_cap_enable),
    .cap(cap_w)
  );

  // Entry and exit tests of fast slowdown
  assign fast_ok = quick_slowdown_enable &&
                   motor_speed < slowdown_speed_ceiling &&
                   mds_gap(motor_speed, target_speed) >=
                   slowdown_min_window;
  assign band_hit = {1'b0, motor_speed} <=
                    {1'b0, target_speed} + {1'b0, slowdown_exit_band};

  // Commutation drive plus rectification; a leg whose comparators both
  // trip, or whose other FET is on, gets nothing extra: no shoot-through
  always_comb begin
    driven = comm_drive;
    if (synchronous_rectify_enable) begin
      driven.upper = comm_drive.upper | (upper_reverse_current_cmp &
        ~lower_reverse_current_cmp & ~comm_drive.lower);
      driven.lower = comm_drive.lower | (lower_reverse_current_cmp &
        ~upper_reverse_current_cmp & ~comm_drive.upper);
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    tick = (s_ff.presc == TICK_LAST);
    nxt_s.presc = tick ? 6'h00 : 6'(s_ff.presc + 6'h01);

    // APB: answer is prepared in the setup cycle, so no wait states
    setup = psel && !penable;
    access = psel && penable && s_ff.pready;
    nxt_s.pready = setup;
    if (setup) begin
      nxt_s.pslverr = 1'b0;
      nxt_s.prdata = 32'h00000000;
      case (paddr)
        `MDS_OFF_CTRL: nxt_s.prdata = {25'h0000000, s_ff.ctrl};
        `MDS_OFF_SLOW: nxt_s.prdata = s_ff.slow;
        `MDS_OFF_WIN: nxt_s.prdata = {8'h00, s_ff.win};
        `MDS_OFF_BTIME: nxt_s.prdata = {16'h0000, s_ff.btime};
        `MDS_OFF_STAT: nxt_s.prdata = {8'h00, s_ff.cap, s_ff.speed_cmd,
                                       3'h0, s_ff.slow_act, s_ff.st};
        default: nxt_s.pslverr = 1'b1;
      endcase
      if (pwrite) begin
        nxt_s.prdata = 32'h00000000;
      end
    end
    if (access && pwrite && !s_ff.pslverr) begin
      case (paddr)
        `MDS_OFF_CTRL: nxt_s.ctrl = pwdata[6:0];
        `MDS_OFF_SLOW: nxt_s.slow = pwdata;
        `MDS_OFF_WIN: nxt_s.win = pwdata[23:0];
        `MDS_OFF_BTIME: nxt_s.btime = pwdata[15:0];
        default: nxt_s.ctrl = s_ff.ctrl;
      endcase
    end

    // Per-state progress
    case (s_ff.st)
      MDS_ST_RUN: begin
        nxt_s.speed_cmd = target_speed;
        if (fast_ok && target_speed < motor_speed) begin
          nxt_s.st = MDS_ST_FASTDEC;
        end
      end
      MDS_ST_FASTDEC: begin
        nxt_s.speed_cmd = target_speed;
        if (!quick_slowdown_enable || band_hit) begin
          nxt_s.st = MDS_ST_RUN;
        end
      end
      MDS_ST_RECIRC: begin
        // Decay time scales with the speed caught at the stop command
        if (s_ff.timer == 16'h0000) begin
          nxt_s.st = MDS_ST_HIZ;
        end else if (tick) begin
          nxt_s.timer = 16'(s_ff.timer - 16'h0001);
        end
      end
      MDS_ST_RAMP: begin
        if (!stop_cmd) begin
          nxt_s.st = MDS_ST_RUN;
        end else if (s_ff.speed_cmd <= brake_entry_speed) begin
          nxt_s.timer = 16'h0000;
          case (stop_style_select)
            3'h2: nxt_s.st = MDS_ST_BRAKE_LO;
            3'h3: nxt_s.st = MDS_ST_BRAKE_HI;
            default: nxt_s.st = MDS_ST_HIZ;
          endcase
        end else if (tick) begin
          nxt_s.speed_cmd = mds_step_down(s_ff.speed_cmd,
                                          brake_entry_speed);
        end
      end
      MDS_ST_BRAKE_LO, MDS_ST_BRAKE_HI: begin
        // Count ticks from brake entry up to the hold time
        if (s_ff.timer >= brake_hold_time) begin
          nxt_s.st = MDS_ST_HIZ;
        end else if (tick) begin
          nxt_s.timer = 16'(s_ff.timer + 16'h0001);
        end
      end
      MDS_ST_HIZ: begin
        nxt_s.speed_cmd = 8'h00;
        if (brake_pin) begin
          nxt_s.st = MDS_ST_PIN_RAMP;
        end else if (!stop_cmd) begin
          nxt_s.st = MDS_ST_RUN;
        end
      end
      MDS_ST_PIN_RAMP: begin
        if (!brake_pin) begin
          nxt_s.st = MDS_ST_RUN;
        end else if (s_ff.speed_cmd <= pin_brake_speed) begin
          nxt_s.st = MDS_ST_PIN_BRAKE;
        end else if (tick) begin
          nxt_s.speed_cmd = mds_step_down(s_ff.speed_cmd, pin_brake_speed);
        end
      end
      MDS_ST_PIN_BRAKE: begin
        if (!brake_pin) begin
          nxt_s.st = MDS_ST_RUN;
        end
      end
      default: nxt_s.st = MDS_ST_HIZ;
    endcase

    // Brake pin, then stop, override motoring and fast slowdown
    if (s_ff.st == MDS_ST_RUN || s_ff.st == MDS_ST_FASTDEC) begin
      if (brake_pin) begin
        nxt_s.st = (motor_speed < pin_brake_speed) ?
                   MDS_ST_PIN_BRAKE : MDS_ST_PIN_RAMP;
        nxt_s.speed_cmd = s_ff.speed_cmd;
      end else if (stop_cmd) begin
        nxt_s.speed_cmd = s_ff.speed_cmd;
        nxt_s.timer = 16'h0000;
        case (stop_style_select)
          3'h1: begin
            nxt_s.st = MDS_ST_RECIRC;
            nxt_s.timer = {8'h00, motor_speed};
            if (hs_mod_active) begin
              nxt_s.held = '{upper: 3'h0, lower: comm_drive.lower};
            end else begin
              nxt_s.held = '{upper: comm_drive.upper, lower: 3'h0};
            end
          end
          3'h2, 3'h3, 3'h4: begin
            if (motor_speed >= brake_entry_speed) begin
              nxt_s.st = MDS_ST_RAMP;
            end else if (stop_style_select == 3'h2) begin
              nxt_s.st = MDS_ST_BRAKE_LO;
            end else if (stop_style_select == 3'h3) begin
              nxt_s.st = MDS_ST_BRAKE_HI;
            end else begin
              nxt_s.st = MDS_ST_HIZ;
            end
          end
          default: nxt_s.st = MDS_ST_HIZ;
        endcase
      end
    end

    // Gates and cap follow the state being entered
    nxt_s.slow_act = (nxt_s.st == MDS_ST_FASTDEC);
    nxt_s.cap = nxt_s.slow_act ? cap_w : 8'h00;
    case (nxt_s.st)
      MDS_ST_BRAKE_LO, MDS_ST_PIN_BRAKE:
        nxt_s.gate = '{upper: 3'h0, lower: 3'h7};
      MDS_ST_BRAKE_HI: nxt_s.gate = '{upper: 3'h7, lower: 3'h0};
      MDS_ST_HIZ: nxt_s.gate = '{upper: 3'h0, lower: 3'h0};
      MDS_ST_RECIRC: nxt_s.gate = nxt_s.held;
      default: nxt_s.gate = driven;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= MDS_RST_STATE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fast_needs_enable: assert property (
    $rose(slowdown_active) |-> $past(quick_slowdown_enable))
    else $error("fast slowdown entered while disabled");
  a_fast_below_ceiling: assert property (
    $rose(slowdown_active) |-> $past(motor_speed) <
                               $past(slowdown_speed_ceiling))
    else $error("fast slowdown entered above ceiling");
  a_fast_min_window: assert property (
    $rose(slowdown_active) |-> mds_gap($past(motor_speed),
      $past(target_speed)) >= $past(slowdown_min_window))
    else $error("fast slowdown entered for a small reduction");
  a_fast_band_exit: assert property (
    s_ff.st == MDS_ST_FASTDEC && band_hit && !brake_pin && !stop_cmd
    |=> s_ff.st == MDS_ST_RUN && !slowdown_active)
    else $error("fast slowdown did not end inside the band");
  a_fixed_cap_hold: assert property (
    slowdown_active && $past(slowdown_active) &&
    !$past(speed_scaled_cap_enable)
    |-> current_cap == $past(slowdown_current_cap))
    else $error("fixed braking cap not applied");
  a_coast_all_off: assert property (
    s_ff.st == MDS_ST_RUN && stop_cmd && !brake_pin &&
    stop_style_select == 3'h0
    |=> gate_drive.upper == 3'h0 && gate_drive.lower == 3'h0)
    else $error("coast stop left a FET on");
  a_recirc_upper_off: assert property (
    s_ff.st == MDS_ST_RUN && stop_cmd && !brake_pin &&
    stop_style_select == 3'h1 && hs_mod_active
    |=> gate_drive.upper == 3'h0 &&
        gate_drive.lower == $past(comm_drive.lower))
    else $error("recirculation with upper modulation wrong");
  a_low_brake_gates: assert property (
    s_ff.st == MDS_ST_BRAKE_LO
    |-> gate_drive.lower == 3'h7 && gate_drive.upper == 3'h0)
    else $error("low brake gates wrong");
  a_pin_brake_hold: assert property (
    (s_ff.st == MDS_ST_PIN_BRAKE && brake_pin) [*2]
    |-> gate_drive.lower == 3'h7 && s_ff.st == MDS_ST_PIN_BRAKE)
    else $error("brake pin hold lost");
  a_demag_upper_a: assert property (
    s_ff.st == MDS_ST_RUN && $past(s_ff.st == MDS_ST_RUN) &&
    $past(synchronous_rectify_enable && upper_reverse_current_cmp[0] &&
          !lower_reverse_current_cmp[0] && !comm_drive.lower[0])
    |-> gate_drive.upper[0])
    else $error("rectification did not turn on upper FET");

  c_fast_slowdown: cover property ($rose(slowdown_active));
  c_low_brake_done: cover property (
    s_ff.st == MDS_ST_BRAKE_LO ##1 s_ff.st == MDS_ST_HIZ);
  c_recirc_done: cover property (
    s_ff.st == MDS_ST_RECIRC ##1 s_ff.st == MDS_ST_HIZ);
  c_pin_brake: cover property ($rose(s_ff.st == MDS_ST_PIN_BRAKE));

endmodule : mds_ctrl

// file: rtl/mds_pkg.sv
// Types and shared helpers of the slowdown and stop controller
package mds_pkg;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MDS_ST_RUN = 4'h0,
    MDS_ST_FASTDEC = 4'h1,
    MDS_ST_RECIRC = 4'h2,
    MDS_ST_RAMP = 4'h3,
    MDS_ST_BRAKE_LO = 4'h4,
    MDS_ST_BRAKE_HI = 4'h5,
    MDS_ST_HIZ = 4'h6,
    MDS_ST_PIN_RAMP = 4'h7,
    MDS_ST_PIN_BRAKE = 4'h8
  } mds_state_code_type;

  // Six gate controls, bit n is phase a/b/c for n = 0/1/2
  typedef struct packed {
    logic [2:0] upper;
    logic [2:0] lower;
  } mds_gate_type;

  // Whole state of the top module
  typedef struct packed {
    mds_state_code_type st;
    logic [6:0] ctrl;
    logic [31:0] slow;
    logic [23:0] win;
    logic [15:0] btime;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] presc;
    logic [15:0] timer;
    mds_gate_type held;
    mds_gate_type gate;
    logic [7:0] speed_cmd;
    logic [7:0] cap;
    logic slow_act;
  } mds_state_type;

  // Saturating difference a - b
  function automatic logic [7:0] mds_gap(input logic [7:0] a,
                                         input logic [7:0] b);
    mds_gap = (a > b) ? 8'(a - b) : 8'h00;
  endfunction : mds_gap

  // One ramp step toward a floor, never below it
  function automatic logic [7:0] mds_step_down(input logic [7:0] cur,
                                               input logic [7:0] floor);
    mds_step_down = (cur > floor) ? 8'(cur - 8'h01) : cur;
  endfunction : mds_step_down

endpackage : mds_pkg

// file: verification/mds_ctrl_tb.sv
// Self-checking bench for the slowdown and stop controller
`timescale 1ns/100ps
module mds_ctrl_tb import mds_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic stop_cmd = 1'b0;
  logic brake_pin = 1'b0;
  logic hs_mod_active = 1'b0;
  logic [7:0] spd = 8'h00;
  logic [7:0] target_speed = 8'h00;
  mds_gate_type comm_drive = 6'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic slowdown_active;
  logic [7:0] motor_speed;
  logic [7:0] speed_cmd;
  logic [7:0] current_cap;
  logic [2:0] up_cmp;
  logic [2:0] lo_cmp;
  mds_gate_type gate_drive;
  int bad_count = 0;
  int checks_done = 0;
  logic [2:0] st_t [4] = '{3'h2, 3'h2, 3'h3, 3'h4};
  logic [7:0] sp_t [4] = '{8'h30, 8'h10, 8'h30, 8'h30};

  // 40 MHz core clock
  always #12.5 pclk = ~pclk;

  mds_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_cmd(stop_cmd), .brake_pin(brake_pin), .motor_speed(motor_speed),
    .target_speed(target_speed), .hs_mod_active(hs_mod_active),
    .comm_drive(comm_drive), .upper_reverse_current_cmp(up_cmp),
    .lower_reverse_current_cmp(lo_cmp), .gate_drive(gate_drive),
    .speed_cmd(speed_cmd), .current_cap(current_cap),
    .slowdown_active(slowdown_active));

  mds_motor_model motor_u (.pclk(pclk), .presetn(presetn),
    .speed_set(spd), .drive(gate_drive), .motor_speed(motor_speed),
    .upper_reverse_current_cmp(up_cmp), .lower_reverse_current_cmp(lo_cmp));

  // ----------------------------------------------------------------
  // Reporting and bus tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic hang(input string what);
    bad_count++;
    $display("MISMATCH %s expected event seen timeout", what);
    conclude();
  endtask : hang

  // One APB transfer; entered just after a rising edge, idles one cycle
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang("pready");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk("prdata", x, q);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask : rd

  // Counts cycles until gate_drive matches v (want=1) or leaves it (want=0)
  task automatic wg(input logic [5:0] v, input logic want, input int lim,
                    output int n);
    n = 0;
    while ((gate_drive === v) !== want && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if ((gate_drive === v) !== want) hang("gate_drive");
  endtask : wg

  task automatic sd(input logic [7:0] s, input logic [7:0] t,
                    input logic x);
    spd <= s;
    target_speed <= t;
    repeat (4) @(posedge pclk);
    chk("slowdown_active", {31'h0, x}, {31'h0, slowdown_active});
  endtask : sd

  task automatic rel();
    stop_cmd <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("gate_drive", 32'h0C, {26'h0, gate_drive});
  endtask : rel

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic [5:0] bp;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, then the unmapped place
    rd(8'h00, 32'h03, 1'b0);
    rd(8'h04, 32'hB3032080, 1'b0);
    rd(8'h08, 32'h001A1A26, 1'b0);
    rd(8'h0C, 32'h3E8, 1'b0);
    rd(8'h14, 32'h0, 1'b1);
    wr(8'h04, 32'h80041040);
    wr(8'h08, 32'h00302010);
    wr(8'h0C, 32'h3);
    rd(8'h04, 32'h80041040, 1'b0);
    // Fast slowdown: ceiling 80, band 4, caps 40/10, window 10
    wr(8'h00, 32'h02);
    sd(8'h70, 8'h40, 1'b0);
    wr(8'h00, 32'h03);
    sd(8'h70, 8'h40, 1'b1);
    chk("cap", 32'h40, {24'h0, current_cap});
    wr(8'h00, 32'h07);
    // The scaled cap is registered one edge after the control write lands
    @(posedge pclk);
    chk("cap", 32'h3A, {24'h0, current_cap});
    sd(8'h45, 8'h40, 1'b1);
    sd(8'h44, 8'h40, 1'b0);
    chk("cap", 32'h0, {24'h0, current_cap});
    sd(8'h90, 8'h40, 1'b0);
    sd(8'h7F, 8'h40, 1'b1);
    // Leave fast slowdown through the band first, so the window is judged
    // on a fresh entry from motoring
    sd(8'h44, 8'h40, 1'b0);
    sd(8'h44, 8'h38, 1'b0);
    sd(8'h44, 8'h34, 1'b1);
    wr(8'h00, 32'h08);
    // Clearing the enable ends slowdown one edge after the write
    @(posedge pclk);
    chk("slowdown_active", 32'h0, {31'h0, slowdown_active});
    // Rectify on: a released upper FET lets the lower diode conduct
    comm_drive <= 6'h08;
    repeat (2) @(posedge pclk);
    comm_drive <= 6'h00;
    wg(6'h01, 1'b1, 20, n);
    wg(6'h01, 1'b0, 20, n);
    chk("lower cmp", 32'h0, {29'h0, lo_cmp});
    wg(6'h08, 1'b1, 20, n);
    wr(8'h00, 32'h00);
    repeat (40) @(posedge pclk);
    comm_drive <= 6'h08;
    repeat (2) @(posedge pclk);
    comm_drive <= 6'h00;
    repeat (3) @(posedge pclk);
    chk("gate_drive", 32'h0, {26'h0, gate_drive});
    comm_drive <= 6'h0C;
    target_speed <= 8'h24;
    spd <= 8'h30;
    repeat (20) @(posedge pclk);
    // Coast
    stop_cmd <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("gate_drive", 32'h0, {26'h0, gate_drive});
    rel();
    // Recirculation with either modulation side, decay of 3 ticks
    for (int h = 0; h < 2; h++) begin
      hs_mod_active <= h[0];
      spd <= 8'h03;
      wr(8'h00, 32'h10);
      stop_cmd <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("gate_drive", h ? 32'h04 : 32'h08, {26'h0, gate_drive});
      wg(6'h00, 1'b1, 200, n);
      chk("recirc time", 32'h1, {31'h0, n > 60});
      rel();
    end
    // Braking styles and spin-down, ramped and direct
    for (int k = 0; k < 4; k++) begin
      bp = (st_t[k] == 3'h2) ? 6'h07 : (st_t[k] == 3'h3) ? 6'h38 : 6'h00;
      spd <= sp_t[k];
      wr(8'h00, {25'h0, st_t[k], 4'h0});
      stop_cmd <= 1'b1;
      wg(bp, 1'b1, 400, n);
      chk("ramp", 32'h1, {31'h0, sp_t[k] < 8'h20 ? n < 4 : n > 100});
      if (sp_t[k] >= 8'h20) begin
        chk("speed_cmd", 32'h20, {24'h0, speed_cmd});
      end
      if (bp != 6'h00) begin
        wg(bp, 1'b0, 200, n);
        chk("brake time", 32'h1, {31'h0, n > 70 && n < 126});
        chk("gate_drive", 32'h0, {26'h0, gate_drive});
      end
      rel();
    end
    // Brake pin: ramp to its threshold, hold lower FETs while high
    spd <= 8'h50;
    target_speed <= 8'h34;
    // Let speed_cmd take the new target before the pin starts its ramp
    repeat (2) @(posedge pclk);
    brake_pin <= 1'b1;
    wg(6'h07, 1'b1, 400, n);
    chk("pin ramp", 32'h1, {31'h0, n > 100});
    chk("speed_cmd", 32'h30, {24'h0, speed_cmd});
    repeat (100) @(posedge pclk);
    chk("gate_drive", 32'h07, {26'h0, gate_drive});
    brake_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("gate_drive", 32'h0C, {26'h0, gate_drive});
    conclude();
  end
endmodule : mds_ctrl_tb

// file: verification/mds_motor_model.sv
// Behavioural motor and bridge: speed source, reverse-current comparators
`timescale 1ns/100ps
module mds_motor_model import mds_pkg::*; #(
  parameter int DECAY = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] speed_set,
  input wire mds_gate_type drive,
  output logic [7:0] motor_speed,
  output logic [2:0] upper_reverse_current_cmp,
  output logic [2:0] lower_reverse_current_cmp
);
  mds_gate_type prev;
  int up_n [3];
  int lo_n [3];

  // Winding current goes on for DECAY cycles after a FET opens, through
  // the body diode of the other FET of that leg; a rectifier that opens
  // also counts, so a cheap model may ping-pong while rectify is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 6'h00;
      up_n <= '{default: 0};
      lo_n <= '{default: 0};
    end else begin
      prev <= drive;
      for (int i = 0; i < 3; i++) begin
        lo_n[i] <= (prev.upper[i] && !drive.upper[i]) ? DECAY :
                   (lo_n[i] > 0) ? lo_n[i] - 1 : 0;
        up_n[i] <= (prev.lower[i] && !drive.lower[i]) ? DECAY :
                   (up_n[i] > 0) ? up_n[i] - 1 : 0;
      end
    end
  end

  // Ground to output trips the lower one, output to supply the upper one
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      lower_reverse_current_cmp[i] = (lo_n[i] > 0);
      upper_reverse_current_cmp[i] = (up_n[i] > 0);
    end
  end

  assign motor_speed = speed_set;
endmodule : mds_motor_model
